// ---- core/mme_pkg.sv ----
//----------------------------------------------------------------------
// mode entry constants
//----------------------------------------------------------------------
// Functional notes
// - blank vector entry adds one reset cycle
// - programmed vector needs test voltage entry
// - watchdog held off after blank entry
// - low interrupt pin, programmed vector: user
// - erased vector fetch forces reset, monitor
// - forced monitor starts on default clock
// - interrupt high: serial pin and clock input
// - interrupt low: only serial pin special
// - monitor: port A bit 2 reads zero
// - monitor: pin branches ignore config enable
// - non power-on resets return forced monitor
// - only power-on reset leaves forced monitor
// - monitor vectors come from page fe
// - vector addresses per mode table
package mme_pkg;
   localparam logic [7:0] mme_erased_byte = 8'hff;
   localparam logic [7:0] mme_user_page = 8'hff;
   localparam logic [7:0] mme_mon_page = 8'hfe;
   localparam logic [7:0] mme_rst_vec_lo = 8'hfe;
   localparam logic [7:0] mme_swi_vec_lo = 8'hfc;
   localparam logic [7:0] mme_rst_vec_lo2 = 8'hff;
   localparam logic [7:0] mme_swi_vec_lo2 = 8'hfd;
   localparam int mme_porta_irq_bit = 2;
   localparam logic [1:0] mme_vsel_reset = 2'h0;
   localparam logic [1:0] mme_vsel_swi = 2'h1;
   localparam logic [1:0] mme_vsel_break = 2'h2;
   typedef enum logic [1:0] {
      mme_idle = 2'b00,
      mme_fetch_hi = 2'b01,
      mme_fetch_lo = 2'b10,
      mme_force_rst = 2'b11
   } mme_state_t;
endpackage : mme_pkg

// ---- core/mme_sync_if.sv ----
`timescale 1ns/10ps
// three-stage pin synchroniser signals
interface mme_sync_if;
   logic pin_raw;
   logic pin_level;
   modport owner (output pin_raw, input pin_level);
   modport sync (input pin_raw, output pin_level);
endinterface : mme_sync_if

// ---- core/mme_pin_sync.sv ----
`timescale 1ns/10ps
// three stage flops and a level flop; level changes once stages two and three agree
module mme_pin_sync
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // pin
   mme_sync_if.sync port_if
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic level;
   logic next_level;

   //----------------------------------------------------------------
   // next values
   //----------------------------------------------------------------
   always_comb
   begin
      next_stage = {stage[1:0], port_if.pin_raw};
      next_level = (stage[2] == stage[1]) ? stage[2] : level;
   end

   // registers
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         stage <= 3'h0;
         level <= 1'b0;
      end
      else
      begin
         stage <= next_stage;
         level <= next_level;
      end
   end

   assign port_if.pin_level = level;
endmodule : mme_pin_sync

// ---- core/mme_mode_entry.sv ----
`timescale 1ns/10ps
// monitor mode entry and vector relocation
module mme_mode_entry
(
   // clock and resets
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic por_in,
   input wire logic other_reset_in,
   // pin levels
   input wire logic int_pin_high_in,
   input wire logic test_voltage_in,
   // vector fetch from the core
   input wire logic vec_fetch_in,
   input wire logic [1:0] vec_sel_in,
   input wire logic vec_lo_half_in,
   input wire logic [7:0] fetch_data_in,
   input wire logic fetch_valid_in,
   // port and branch support
   input wire logic [7:0] porta_read_in,
   input wire logic int_pin_cfg_en_in,
   // mode and addresses
   output logic monitor_mode_out,
   output logic forced_monitor_out,
   output logic internal_reset_out,
   output logic watchdog_disable_out,
   output logic default_clock_out,
   output logic [15:0] vec_addr_out,
   // pin functions
   output logic serial_comm_pin_out,
   output logic ext_clock_input_pin_out,
   output logic [7:0] porta_read_out,
   output logic int_branch_en_out
);
   mme_sync_if int_if ();
   mme_sync_if tst_if ();

   assign int_if.pin_raw = int_pin_high_in;
   assign tst_if.pin_raw = test_voltage_in;

   mme_pin_sync u_int_sync
   (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .port_if(int_if)
   );

   mme_pin_sync u_tst_sync
   (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .port_if(tst_if)
   );

   //----------------------------------------------------------------
   // state
   //----------------------------------------------------------------
   mme_pkg::mme_state_t state;
   mme_pkg::mme_state_t next_state;
   // mode flags
   logic monitor;
   logic next_monitor;
   logic forced;
   logic next_forced;
   // blank vector watch
   logic hi_erased;
   logic next_hi_erased;
   logic irst;
   logic next_irst;
   // vector address and pin function registers
   logic [15:0] vaddr;
   logic [15:0] next_vaddr;
   logic [7:0] pa_read;
   logic [7:0] next_pa_read;
   logic ser_fn;
   logic next_ser_fn;
   logic clk_fn;
   logic next_clk_fn;
   logic br_en;
   logic next_br_en;
   // combinational helpers
   logic [7:0] page;
   logic [7:0] lo_byte;
   logic reset_any;

   //----------------------------------------------------------------
   // mode decision and blank vector watch
   //----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_monitor = monitor;
      next_forced = forced;
      next_hi_erased = hi_erased;
      next_irst = 1'b0;
      // the extra reset pulse acts like any other reset
      reset_any = por_in | other_reset_in | irst;
      if (por_in)
      begin
         // power-on alone clears the forced flag
         next_forced = 1'b0;
         next_monitor = tst_if.pin_level;
         next_state = mme_pkg::mme_idle;
      end
      else if (reset_any)
      begin
         // forced monitor survives every other reset
         next_monitor = forced | tst_if.pin_level;
         next_state = mme_pkg::mme_idle;
      end
      else
      begin
         case (state)
            mme_pkg::mme_idle:
               if (vec_fetch_in && !monitor &&
                   vec_sel_in == mme_pkg::mme_vsel_reset)
                  next_state = mme_pkg::mme_fetch_hi;
            mme_pkg::mme_fetch_hi:
               // another vector's bytes end the watch
               if (vec_sel_in != mme_pkg::mme_vsel_reset)
                  next_state = mme_pkg::mme_idle;
               else if (fetch_valid_in && !vec_lo_half_in)
               begin
                  next_hi_erased =
                     (fetch_data_in == mme_pkg::mme_erased_byte);
                  next_state = mme_pkg::mme_fetch_lo;
               end
            mme_pkg::mme_fetch_lo:
               if (vec_sel_in != mme_pkg::mme_vsel_reset)
                  next_state = mme_pkg::mme_idle;
               else if (fetch_valid_in && vec_lo_half_in)
               begin
                  // both bytes erased: internal reset
                  if (hi_erased &&
                      fetch_data_in == mme_pkg::mme_erased_byte)
                     next_state = mme_pkg::mme_force_rst;
                  else
                     next_state = mme_pkg::mme_idle;
               end
            mme_pkg::mme_force_rst:
            begin
               next_irst = 1'b1; // one extra reset cycle
               next_forced = 1'b1; // no test voltage needed
               next_state = mme_pkg::mme_idle;
            end
            default:
               next_state = mme_pkg::mme_idle;
         endcase
      end
   end

   //----------------------------------------------------------------
   // vector address and pin defaults
   //----------------------------------------------------------------
   always_comb
   begin
      // monitor flag picks page fe instead of ff
      page = next_monitor ? mme_pkg::mme_mon_page :
                            mme_pkg::mme_user_page;
      if (vec_sel_in == mme_pkg::mme_vsel_reset)
         lo_byte = vec_lo_half_in ? mme_pkg::mme_rst_vec_lo2 :
                                    mme_pkg::mme_rst_vec_lo;
      else // break and software_interrupt share one vector
         lo_byte = vec_lo_half_in ? mme_pkg::mme_swi_vec_lo2 :
                                    mme_pkg::mme_swi_vec_lo;
      next_vaddr = {page, lo_byte};
      next_pa_read = porta_read_in;
      if (next_monitor)
         next_pa_read[mme_pkg::mme_porta_irq_bit] = 1'b0;
      // serial port in monitor for either pin level
      next_ser_fn = next_monitor;
      // clock input only with interrupt pin high
      next_clk_fn = next_monitor & int_if.pin_level;
      // branches see the pin as enabled in monitor
      next_br_en = next_monitor | int_pin_cfg_en_in;
   end

   // registers
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         state <= mme_pkg::mme_idle;
         monitor <= 1'b0;
         forced <= 1'b0;
         hi_erased <= 1'b0;
         irst <= 1'b0;
         vaddr <= {mme_pkg::mme_user_page, mme_pkg::mme_rst_vec_lo};
         pa_read <= 8'h00;
         ser_fn <= 1'b0;
         clk_fn <= 1'b0;
         br_en <= 1'b0;
      end
      else
      begin
         state <= next_state;
         monitor <= next_monitor;
         forced <= next_forced;
         hi_erased <= next_hi_erased;
         irst <= next_irst;
         vaddr <= next_vaddr;
         pa_read <= next_pa_read;
         ser_fn <= next_ser_fn;
         clk_fn <= next_clk_fn;
         br_en <= next_br_en;
      end
   end

   //----------------------------------------------------------------
   // outputs straight from flops
   //----------------------------------------------------------------
   assign monitor_mode_out = monitor;
   assign forced_monitor_out = forced;
   assign internal_reset_out = irst;
   assign watchdog_disable_out = forced;
   assign default_clock_out = forced;
   assign vec_addr_out = vaddr;
   assign serial_comm_pin_out = ser_fn;
   assign ext_clock_input_pin_out = clk_fn;
   assign porta_read_out = pa_read;
   assign int_branch_en_out = br_en;
endmodule : mme_mode_entry

// ---- test/mme_mode_entry_assertions.sv ----
`timescale 1ns/10ps
// ---
// mode entry checks
// ---
module mme_mode_entry_assertions
(
   // clock and resets
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic por_in,
   // watched outputs
   input wire logic monitor_mode_out,
   input wire logic forced_monitor_out,
   input wire logic internal_reset_out,
   input wire logic watchdog_disable_out,
   input wire logic [15:0] vec_addr_out,
   input wire logic [7:0] porta_read_out,
   input wire logic int_branch_en_out
);
   // one domain: shared clock and reset
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wd_forced_a: assert property (
      watchdog_disable_out == forced_monitor_out &&
      (!watchdog_disable_out || monitor_mode_out || internal_reset_out))
      else $error("wd");
   blank_entry_a: assert property (
      internal_reset_out |-> forced_monitor_out ##1 monitor_mode_out)
      else $error("entry");
   forced_hold_a: assert property (
      forced_monitor_out && !por_in |=> forced_monitor_out)
      else $error("forced lost");
   forced_mon_a: assert property (
      $past(forced_monitor_out) && forced_monitor_out |-> monitor_mode_out)
      else $error("forced mon");
   mon_page_a: assert property (
      $past(monitor_mode_out) && monitor_mode_out
      |-> vec_addr_out[15:8] == 8'hfe) else $error("mon page");
   user_page_a: assert property (
      !$past(monitor_mode_out) && !monitor_mode_out
      |-> vec_addr_out[15:8] == 8'hff) else $error("user page");
   bit2_zero_a: assert property (
      $past(monitor_mode_out) && monitor_mode_out |-> !porta_read_out[2])
      else $error("bit2");
   branch_en_a: assert property (
      $past(monitor_mode_out) && monitor_mode_out |-> int_branch_en_out)
      else $error("branch");
endmodule : mme_mode_entry_assertions

bind mme_mode_entry mme_mode_entry_assertions mme_mode_entry_assertions_inst
(
   .clk_in(clk_in),
   .reset_in(reset_in),
   .por_in(por_in),
   .monitor_mode_out(monitor_mode_out),
   .forced_monitor_out(forced_monitor_out),
   .internal_reset_out(internal_reset_out),
   .watchdog_disable_out(watchdog_disable_out),
   .vec_addr_out(vec_addr_out),
   .porta_read_out(porta_read_out),
   .int_branch_en_out(int_branch_en_out)
);

// ---- test/tb_mme_mode_entry.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
   failures++; $display("ERROR %0t mismatch", $time); end end
// ---
// mode entry bench
// ---
module tb_mme_mode_entry;
   // stimulus, outputs and counters
   logic clk_in, reset_in, por_in, other_reset_in, int_pin_high_in;
   logic test_voltage_in, vec_fetch_in, vec_lo_half_in, fetch_valid_in;
   logic int_pin_cfg_en_in, monitor_mode_out, forced_monitor_out, seen;
   logic internal_reset_out, watchdog_disable_out, default_clock_out;
   logic serial_comm_pin_out, ext_clock_input_pin_out, int_branch_en_out;
   logic [1:0] vec_sel_in;
   logic [7:0] fetch_data_in, porta_read_in, porta_read_out;
   logic [15:0] vec_addr_out;
   int failures = 0;
   int num_checks = 0;
   mme_mode_entry mme_mode_entry_inst
   (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .por_in(por_in),
      .other_reset_in(other_reset_in),
      .int_pin_high_in(int_pin_high_in),
      .test_voltage_in(test_voltage_in),
      .vec_fetch_in(vec_fetch_in),
      .vec_sel_in(vec_sel_in),
      .vec_lo_half_in(vec_lo_half_in),
      .fetch_data_in(fetch_data_in),
      .fetch_valid_in(fetch_valid_in),
      .porta_read_in(porta_read_in),
      .int_pin_cfg_en_in(int_pin_cfg_en_in),
      .monitor_mode_out(monitor_mode_out),
      .forced_monitor_out(forced_monitor_out),
      .internal_reset_out(internal_reset_out),
      .watchdog_disable_out(watchdog_disable_out),
      .default_clock_out(default_clock_out),
      .vec_addr_out(vec_addr_out),
      .serial_comm_pin_out(serial_comm_pin_out),
      .ext_clock_input_pin_out(ext_clock_input_pin_out),
      .porta_read_out(porta_read_out),
      .int_branch_en_out(int_branch_en_out)
   );
   // clock
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask : tick
   task automatic finish_test;
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   // every vector address for one page
   task automatic vecs(input logic [7:0] p);
      logic [15:0] exp_addr;
      for (int i = 0; i < 6; i++)
      begin
         vec_sel_in = 2'(i / 2);
         vec_lo_half_in = i[0];
         // reset vector at fe/ff, the other two share fc/fd
         exp_addr = {p, (i < 2) ? 8'hfe : 8'hfc} + 16'(i % 2);
         tick(2);
         `CHK(vec_addr_out, exp_addr)
      end
   endtask : vecs
   // reset vector fetch, high byte erased, low byte b
   task automatic fetch(input logic [7:0] b);
      vec_sel_in = 2'h0;
      vec_lo_half_in = 1'b0;
      vec_fetch_in = 1'b1;
      tick(1);
      vec_fetch_in = 1'b0;
      fetch_valid_in = 1'b1;
      fetch_data_in = 8'hff;
      tick(1);
      vec_lo_half_in = 1'b1;
      fetch_data_in = b;
      tick(1);
      fetch_valid_in = 1'b0;
      seen = 1'b0;
      repeat (8)
      begin
         tick(1);
         seen |= internal_reset_out;
      end
   endtask : fetch
   task automatic user_test;
      fetch(8'h00);
      `CHK(seen, 1'b0)
      `CHK(monitor_mode_out, 1'b0)
      `CHK(porta_read_out, 8'hff)
      `CHK(int_branch_en_out, 1'b0)
      int_pin_cfg_en_in = 1'b1;
      tick(2);
      `CHK(int_branch_en_out, 1'b1)
      int_pin_cfg_en_in = 1'b0;
      vecs(8'hff);
   endtask : user_test
   task automatic blank_test;
      fetch(8'hff);
      `CHK(seen, 1'b1)
      `CHK(monitor_mode_out, 1'b1)
      `CHK(default_clock_out, 1'b1)
      `CHK(porta_read_out, 8'hfb)
      `CHK(int_branch_en_out, 1'b1)
      `CHK(serial_comm_pin_out, 1'b1)
      `CHK(ext_clock_input_pin_out, 1'b0)
      int_pin_high_in = 1'b1;
      tick(8);
      `CHK(ext_clock_input_pin_out, 1'b1)
      `CHK(watchdog_disable_out, 1'b1)
      vecs(8'hfe);
      other_reset_in = 1'b1;
      tick(2);
      other_reset_in = 1'b0;
      tick(4);
      `CHK(forced_monitor_out, 1'b1)
      `CHK(monitor_mode_out, 1'b1)
   endtask : blank_test
   // power-on reset with and without test voltage
   task automatic por_test(input logic tv);
      test_voltage_in = tv;
      tick(6);
      por_in = 1'b1;
      tick(2);
      por_in = 1'b0;
      tick(2);
      `CHK(forced_monitor_out, 1'b0)
      `CHK(watchdog_disable_out, 1'b0)
      `CHK(monitor_mode_out, tv)
   endtask : por_test
   // main sequence
   initial
   begin
      {reset_in, por_in, other_reset_in, int_pin_high_in} = 4'h8;
      {test_voltage_in, vec_fetch_in, vec_lo_half_in} = 3'h0;
      {fetch_valid_in, int_pin_cfg_en_in, seen} = 3'h0;
      {vec_sel_in, fetch_data_in, porta_read_in} = {2'h0, 8'h00, 8'hff};
      tick(16);
      reset_in = 1'b0;
      tick(2);
      user_test();
      blank_test();
      por_test(1'b1);
      por_test(1'b0);
      finish_test();
   end
   // watchdog against a hang
   initial
   begin
      #20000;
      failures++;
      finish_test();
   end
endmodule : tb_mme_mode_entry
